// [deac_pkg.sv]
// Purpose: Shared constants and types for the data EEPROM access control block.
// Assumes: 8-bit special-function-register bus, 10 MHz system clock.
// Notes:   All SFR addresses live in one flat 8-bit space, bank 0 unless stated.
package deac_pkg;

	// Storage geometry
	localparam int unsigned NVM_DEPTH        = 64;
	localparam int unsigned NVM_AW           = 6;
	localparam int unsigned NVM_DW           = 8;

	// SFR addresses
	localparam logic [7:0]  ADDR_IND_PORT    = 8'h02;
	localparam logic [7:0]  ADDR_POINTER_ONE = 8'h03;
	localparam logic [7:0]  ADDR_BANK_SELECT = 8'h04;
	localparam logic [7:0]  ADDR_INTC        = 8'h0B;
	localparam logic [7:0]  ADDR_BYTE_INDEX  = 8'h1E;
	localparam logic [7:0]  ADDR_BYTE_BUFFER = 8'h1F;

	// Control register location behind the indirect port
	localparam logic [7:0]  CTRL_POINTER     = 8'h40;
	localparam logic [7:0]  CTRL_BANK        = 8'h01;

	// Control register fields
	localparam int unsigned CTL_FETCH_TRIG   = 0;
	localparam int unsigned CTL_FETCH_PERMIT = 1;
	localparam int unsigned CTL_WRITE_TRIG   = 2;
	localparam int unsigned CTL_PROG_PERMIT  = 3;

	// Interrupt control register fields
	localparam int unsigned INTC_GLOBAL_EN   = 0;
	localparam int unsigned INTC_MF_EN       = 1;
	localparam int unsigned INTC_NVM_EN      = 2;
	localparam int unsigned INTC_MF_FLAG     = 3;
	localparam int unsigned INTC_NVM_FLAG    = 4;

	// Timing
	localparam int unsigned CLK_PERIOD_NS    = 100;
	localparam int unsigned WRITE_TIME_US    = 200;
	localparam int unsigned WRITE_CYCLES_DEF = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned READ_CYCLES      = 2;
	localparam int unsigned CNT_W            = 16;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'h0,
		PH_READ  = 2'h1,
		PH_WRITE = 2'h2
	} deac_phase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} deac_sfr_req_t;

	typedef struct packed {
		logic [NVM_AW-1:0] byte_index;
		logic [NVM_DW-1:0] byte_buffer;
		logic [7:0]        bank_select;
		logic [7:0]        pointer_one;
		logic              program_permit;
		logic              write_trig;
		logic              fetch_permit;
		logic              fetch_trig;
		logic              permit_fresh;
		deac_phase_t       phase;
		logic [CNT_W-1:0]  count;
		logic [NVM_AW-1:0] op_addr;
		logic [NVM_DW-1:0] op_data;
		logic              global_en;
		logic              mf_en;
		logic              nvm_irq_enable;
		logic              mf_flag;
		logic              nvm_irq_flag;
		logic [7:0]        rdata;
		logic              vec_req;
	} deac_state_t;

	localparam deac_state_t DEAC_STATE_RESET = '0;

endpackage

// [deac_store.sv]
// Purpose: Byte array holding the non-volatile data contents.
// Assumes: Single write port, asynchronous read port.
// Notes:   No reset, contents persist like the real array.
module deac_store
	import deac_pkg::*;
#(
	parameter int unsigned DEPTH = NVM_DEPTH,
	parameter int unsigned AW    = NVM_AW,
	parameter int unsigned DW    = NVM_DW
) (
	input  wire logic          ref_clk,
	input  wire logic          ce,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule

// [deac_ctrl.sv]
// Purpose: Data EEPROM access control: registers, protection, cycles, interrupt.
// Assumes: CPU SFR bus on ref_clk, one access per cycle, int_ack from the CPU.
// Notes:   Control register reachable only through the indirect port.
//
// Overview of operation
// RULE1: Reset clears program permit so no write can start.
// RULE2: Reset puts bank select at zero, hiding the control register.
// RULE3: End of any read or write cycle raises the memory request.
// RULE4: Memory interrupt needs its own and the shared enable set.
// RULE5: Write end sets both memory flag and shared flag.
// RULE6: Vector request needs global, memory, shared enables and stack room.
// RULE7: Service clears only the shared flag; software clears the memory flag.
// RULE8: Write trigger counts only in the write right after setting permit.
// RULE9: Software keeps program permit low when not writing.
// RULE10: Software keeps bank select at zero in normal running.
// RULE11: Control register only via pointer 40h, indirect port, bank 01h.
// RULE12: Read: set fetch permit, then trigger bit 0, poll until cleared.
// RULE13: Write: load index and data, permit bit 3, trigger bit 2, poll.
// RULE14: Software clears whole control register then bank select after access.
// RULE15: Software may read back written data to verify it.
// RULE16: Byte index has six bits; upper two read as zero.
// RULE17: Trigger ignored unless its permit is already set; cleared at cycle end.
// RULE18: Buffer keeps read byte until another read or write.
// RULE19: Setting both triggers together is refused.
// RULE20: Write cycle timed by a counter; trigger stays set until expiry.
// RULE21: Read cycle completes a fixed few clocks after acceptance.
module deac_ctrl
	import deac_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	input  wire logic          ref_clk,
	input  wire logic          resetn,
	input  wire logic          ce,
	input  wire deac_sfr_req_t sfr_req,
	input  wire logic          stack_full,
	input  wire logic          int_ack,
	output logic [7:0]         sfr_rdata,
	output logic               vector_req
);

	localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYCLES - 1);
	localparam logic [CNT_W-1:0] READ_LOAD  = CNT_W'(READ_CYCLES - 1);
	localparam int               READ_MAX   = 8;

	deac_state_t       st;
	deac_state_t       next_st;
	logic              ctl_sel;
	logic              ctl_wr;
	logic              buf_wr;
	logic              intc_wr;
	logic              start_fetch;
	logic              start_write;
	logic              store_we;
	logic [NVM_DW-1:0] store_rd_data;
	logic [7:0]        rd_mux;

	function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
		sfr_hit = (addr == target);
	endfunction

	function automatic logic [7:0] ctl_image(input deac_state_t s);
		ctl_image = 8'h00;
		ctl_image[CTL_FETCH_TRIG]   = s.fetch_trig;
		ctl_image[CTL_FETCH_PERMIT] = s.fetch_permit;
		ctl_image[CTL_WRITE_TRIG]   = s.write_trig;
		ctl_image[CTL_PROG_PERMIT]  = s.program_permit;
	endfunction

	function automatic logic [7:0] intc_image(input deac_state_t s);
		intc_image = 8'h00;
		intc_image[INTC_GLOBAL_EN] = s.global_en;
		intc_image[INTC_MF_EN]     = s.mf_en;
		intc_image[INTC_NVM_EN]    = s.nvm_irq_enable;
		intc_image[INTC_MF_FLAG]   = s.mf_flag;
		intc_image[INTC_NVM_FLAG]  = s.nvm_irq_flag;
	endfunction

	deac_store #(
		.DEPTH (NVM_DEPTH),
		.AW    (NVM_AW),
		.DW    (NVM_DW)
	) u_store (
		.ref_clk (ref_clk),
		.ce      (ce),
		.wr_en   (store_we),
		.wr_addr (st.op_addr),
		.wr_data (st.op_data),
		.rd_addr (st.op_addr),
		.rd_data (store_rd_data)
	);

	// Access decode
	assign ctl_sel = (st.bank_select == CTRL_BANK) && (st.pointer_one == CTRL_POINTER); // RULE11
	assign ctl_wr  = sfr_req.we && sfr_hit(sfr_req.addr, ADDR_IND_PORT) && ctl_sel; // RULE11
	assign buf_wr  = sfr_req.we && sfr_hit(sfr_req.addr, ADDR_BYTE_BUFFER);
	assign intc_wr = sfr_req.we && sfr_hit(sfr_req.addr, ADDR_INTC);

	// Trigger acceptance
	assign start_fetch = ctl_wr && sfr_req.wdata[CTL_FETCH_TRIG] && !sfr_req.wdata[CTL_WRITE_TRIG]
		&& st.fetch_permit && (st.phase == PH_IDLE); // RULE17 RULE19 RULE12
	assign start_write = ctl_wr && sfr_req.wdata[CTL_WRITE_TRIG] && !sfr_req.wdata[CTL_FETCH_TRIG]
		&& st.program_permit && st.permit_fresh && (st.phase == PH_IDLE); // RULE8 RULE17 RULE19 RULE13

	assign store_we = (st.phase == PH_WRITE) && (st.count == '0);

	// Read multiplexer
	always_comb begin
		rd_mux = 8'h00;
		if (sfr_hit(sfr_req.addr, ADDR_BYTE_INDEX)) begin
			rd_mux = {2'h0, st.byte_index}; // RULE16
		end else if (sfr_hit(sfr_req.addr, ADDR_BYTE_BUFFER)) begin
			rd_mux = st.byte_buffer;
		end else if (sfr_hit(sfr_req.addr, ADDR_BANK_SELECT)) begin
			rd_mux = st.bank_select;
		end else if (sfr_hit(sfr_req.addr, ADDR_POINTER_ONE)) begin
			rd_mux = st.pointer_one;
		end else if (sfr_hit(sfr_req.addr, ADDR_INTC)) begin
			rd_mux = intc_image(st);
		end else if (sfr_hit(sfr_req.addr, ADDR_IND_PORT) && ctl_sel) begin
			rd_mux = ctl_image(st); // RULE12 RULE13
		end
	end

	always_comb begin
		next_st = st;
		// Software side
		if (sfr_req.we) begin
			next_st.permit_fresh = 1'b0; // RULE8
			if (sfr_hit(sfr_req.addr, ADDR_BYTE_INDEX)) begin
				next_st.byte_index = sfr_req.wdata[NVM_AW-1:0]; // RULE16
			end
			if (buf_wr) begin
				next_st.byte_buffer = sfr_req.wdata;
			end
			if (sfr_hit(sfr_req.addr, ADDR_BANK_SELECT)) begin
				next_st.bank_select = sfr_req.wdata;
			end
			if (sfr_hit(sfr_req.addr, ADDR_POINTER_ONE)) begin
				next_st.pointer_one = sfr_req.wdata;
			end
			if (intc_wr) begin
				next_st.global_en      = sfr_req.wdata[INTC_GLOBAL_EN];
				next_st.mf_en          = sfr_req.wdata[INTC_MF_EN];
				next_st.nvm_irq_enable = sfr_req.wdata[INTC_NVM_EN];
				next_st.mf_flag        = sfr_req.wdata[INTC_MF_FLAG];
				next_st.nvm_irq_flag   = sfr_req.wdata[INTC_NVM_FLAG]; // RULE7
			end
			if (ctl_wr) begin
				next_st.program_permit = sfr_req.wdata[CTL_PROG_PERMIT]; // RULE14
				next_st.fetch_permit   = sfr_req.wdata[CTL_FETCH_PERMIT]; // RULE14
				next_st.permit_fresh   = sfr_req.wdata[CTL_PROG_PERMIT] && !st.program_permit; // RULE8
			end
		end
		if (sfr_req.re) begin
			next_st.rdata = rd_mux;
		end
		// Service clears only the shared flag
		if (int_ack) begin
			next_st.mf_flag = 1'b0; // RULE7
		end
		// Cycle sequencing; hardware sets win over clears above
		unique case (st.phase)
			PH_IDLE: begin
				if (start_fetch) begin
					next_st.phase      = PH_READ;
					next_st.fetch_trig = 1'b1; // RULE12
					next_st.count      = READ_LOAD; // RULE21
					next_st.op_addr    = st.byte_index;
				end else if (start_write) begin
					next_st.phase      = PH_WRITE;
					next_st.write_trig = 1'b1; // RULE13
					next_st.count      = WRITE_LOAD; // RULE20
					next_st.op_addr    = st.byte_index;
					next_st.op_data    = buf_wr ? sfr_req.wdata : st.byte_buffer;
				end
			end
			PH_READ: begin
				if (st.count == '0) begin
					next_st.phase        = PH_IDLE;
					next_st.fetch_trig   = 1'b0; // RULE17
					next_st.byte_buffer  = store_rd_data; // RULE18
					next_st.nvm_irq_flag = 1'b1; // RULE3
					next_st.mf_flag      = 1'b1; // RULE3
				end else begin
					next_st.count = st.count - 1'b1; // RULE21
				end
			end
			PH_WRITE: begin
				if (st.count == '0) begin
					next_st.phase        = PH_IDLE;
					next_st.write_trig   = 1'b0; // RULE17 RULE20
					next_st.nvm_irq_flag = 1'b1; // RULE3 RULE5
					next_st.mf_flag      = 1'b1; // RULE5
				end else begin
					next_st.count = st.count - 1'b1; // RULE20
				end
			end
			default: begin
				next_st.phase      = PH_IDLE;
				next_st.fetch_trig = 1'b0;
				next_st.write_trig = 1'b0;
			end
		endcase
		// Vector request gating
		next_st.vec_req = st.global_en && st.mf_en && st.nvm_irq_enable
			&& st.mf_flag && !stack_full; // RULE4 RULE6
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st <= DEAC_STATE_RESET; // RULE1 RULE2
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign sfr_rdata  = st.rdata;
	assign vector_req = st.vec_req;

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	a_fetch_needs_permit: assert property ($rose(st.fetch_trig) |-> $past(st.fetch_permit)) // RULE17
		else $error("fetch trigger rose without fetch permit");
	a_write_needs_fresh: assert property ($rose(st.write_trig) |-> $past(st.permit_fresh) && $past(st.program_permit)) // RULE8
		else $error("write started without freshly set permit");
	a_no_dual_trig: assert property (!(st.fetch_trig && st.write_trig)) // RULE19
		else $error("both triggers set");
	a_read_end_flags: assert property (ce && st.phase == PH_READ && st.count == '0 |=> !st.fetch_trig && st.nvm_irq_flag && st.mf_flag) // RULE3
		else $error("read end did not clear trigger and raise flags");
	a_read_bounded: assert property (ce throughout ($rose(st.fetch_trig) ##1 1'b1 [*1]) |-> ##[0:READ_MAX] !st.fetch_trig) // RULE21
		else $error("read cycle too long");
	a_write_end_flags: assert property (ce && st.phase == PH_WRITE && st.count == '0 |=> !st.write_trig && st.nvm_irq_flag && st.mf_flag) // RULE5
		else $error("write end did not clear trigger and raise both flags");
	a_write_holds_trig: assert property (st.phase == PH_WRITE && st.count != '0 |=> st.write_trig) // RULE20
		else $error("write trigger dropped before counter expiry");
	a_vector_gating: assert property (ce && vector_req |-> $past(st.global_en && st.mf_en && st.nvm_irq_enable && !stack_full)) // RULE6
		else $error("vector request without all enables");
	a_ack_keeps_nvm: assert property (ce && int_ack && st.nvm_irq_flag && !intc_wr |=> st.nvm_irq_flag) // RULE7
		else $error("service cleared memory flag");
	a_buffer_holds: assert property (st.phase == PH_IDLE && !buf_wr |=> $stable(st.byte_buffer)) // RULE18
		else $error("buffer changed without access");
	a_bank_hides_ctl: assert property (st.bank_select != CTRL_BANK && !st.fetch_trig |=> !$rose(st.fetch_trig)) // RULE11
		else $error("control register reached outside bank one");

	c_read_done: cover property (st.phase == PH_READ ##1 st.phase == PH_IDLE);
	c_write_done: cover property (st.phase == PH_WRITE ##1 st.phase == PH_IDLE);
	c_vector: cover property ($rose(vector_req));
	c_write_refused: cover property (ctl_wr && sfr_req.wdata[CTL_WRITE_TRIG] && st.program_permit && !st.permit_fresh);

endmodule

// [tb.sv]
// Purpose: Self-checking bench for the data EEPROM access control block.
// Assumes: Block instantiates its own store; short write time via WRITE_CYCLES.
// Notes:   SFR traffic driven 1 ns after each rising edge.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import deac_pkg::*;

	logic          ref_clk;
	logic          resetn;
	logic          ce;
	deac_sfr_req_t sfr_req;
	logic          stack_full;
	logic          int_ack;
	logic [7:0]    sfr_rdata;
	logic          vector_req;
	int            err_total;
	int            compares;
	logic [7:0]    v;
	logic [7:0]    idx;
	logic [7:0]    dat;

	deac_ctrl #(.WRITE_CYCLES(4)) deac_ctrl_inst (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.ce         (ce),
		.sfr_req    (sfr_req),
		.stack_full (stack_full),
		.int_ack    (int_ack),
		.sfr_rdata  (sfr_rdata),
		.vector_req (vector_req)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Write strobe stays high so writes can go back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_req.addr = a;
		sfr_req.wdata = d;
		sfr_req.we = 1'b1;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic idle(input int n);
		sfr_req.we = 1'b0;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_req.we = 1'b0;
		sfr_req.addr = a;
		sfr_req.re = 1'b1;
		@(posedge ref_clk);
		#1;
		sfr_req.re = 1'b0;
		@(posedge ref_clk);
		#1;
		d = sfr_rdata;
	endtask

	task automatic poll(input logic [7:0] m, input int lim);
		logic [7:0] r;
		int         n;
		n = 0;
		do begin
			rd(ADDR_IND_PORT, r);
			n++;
		end while ((r & m) !== 8'h00 && n < lim);
		chk(r & m, 8'h00);
	endtask

	task automatic nvm_write(input logic [7:0] i, input logic [7:0] d);
		wr(ADDR_BYTE_INDEX, i);
		wr(ADDR_BYTE_BUFFER, d);
		wr(ADDR_INTC, 8'h00);
		wr(ADDR_POINTER_ONE, CTRL_POINTER);
		wr(ADDR_BANK_SELECT, CTRL_BANK);
		wr(ADDR_IND_PORT, 8'h00);
		wr(ADDR_IND_PORT, 8'h08);
		wr(ADDR_IND_PORT, 8'h0C);
		idle(1);
		rd(ADDR_IND_PORT, v);
		chk(v, 8'h0C);
		poll(8'h04, 10);
		rd(ADDR_INTC, v);
		chk(v & 8'h18, 8'h18);
		wr(ADDR_IND_PORT, 8'h00);
		wr(ADDR_BANK_SELECT, 8'h00);
	endtask

	task automatic nvm_read(input logic [7:0] i, input logic [7:0] e);
		wr(ADDR_BYTE_INDEX, i);
		wr(ADDR_INTC, 8'h00);
		wr(ADDR_POINTER_ONE, CTRL_POINTER);
		wr(ADDR_BANK_SELECT, CTRL_BANK);
		wr(ADDR_IND_PORT, 8'h02);
		wr(ADDR_IND_PORT, 8'h03);
		idle(1);
		poll(8'h01, 3);
		rd(ADDR_INTC, v);
		chk(v & 8'h18, 8'h18);
		rd(ADDR_BYTE_BUFFER, v);
		chk(v, e);
		wr(ADDR_BYTE_INDEX, i ^ 8'h15);
		wr(ADDR_IND_PORT, 8'h00);
		wr(ADDR_BANK_SELECT, 8'h00);
		rd(ADDR_BYTE_BUFFER, v);
		chk(v, e);
	endtask

	initial begin
		#2_000_000;
		err_total++;
		end_sim();
	end

	initial begin
		err_total = 0;
		compares = 0;
		resetn = 1'b0;
		ce = 1'b1;
		sfr_req = '0;
		stack_full = 1'b0;
		int_ack = 1'b0;
		void'($urandom(18));
		repeat (6) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		// Protection state after reset
		rd(ADDR_BANK_SELECT, v);
		chk(v, 8'h00);
		wr(ADDR_POINTER_ONE, CTRL_POINTER);
		wr(ADDR_IND_PORT, 8'h02);
		wr(ADDR_BANK_SELECT, CTRL_BANK);
		rd(ADDR_IND_PORT, v);
		chk(v, 8'h00);
		wr(ADDR_IND_PORT, 8'h01);
		rd(ADDR_IND_PORT, v);
		chk(v, 8'h00);
		wr(ADDR_IND_PORT, 8'h02);
		wr(ADDR_POINTER_ONE, 8'h41);
		rd(ADDR_IND_PORT, v);
		chk(v, 8'h00);
		wr(ADDR_POINTER_ONE, CTRL_POINTER);
		rd(ADDR_IND_PORT, v);
		chk(v, 8'h02);
		// Late trigger and double trigger refused
		wr(ADDR_IND_PORT, 8'h00);
		wr(ADDR_IND_PORT, 8'h08);
		wr(ADDR_BYTE_INDEX, 8'h05);
		wr(ADDR_IND_PORT, 8'h0C);
		idle(1);
		rd(ADDR_IND_PORT, v);
		chk(v, 8'h08);
		wr(ADDR_IND_PORT, 8'h00);
		wr(ADDR_IND_PORT, 8'h0A);
		wr(ADDR_IND_PORT, 8'h0F);
		idle(1);
		rd(ADDR_IND_PORT, v);
		chk(v, 8'h0A);
		wr(ADDR_IND_PORT, 8'h00);
		wr(ADDR_BANK_SELECT, 8'h00);
		// Boundary and random traffic
		nvm_write(8'h3F, 8'hA5);
		nvm_write(8'h00, 8'h5A);
		nvm_read(8'h3F, 8'hA5);
		nvm_read(8'h00, 8'h5A);
		for (int k = 0; k < 4; k++) begin
			idx = 8'($urandom);
			dat = 8'($urandom);
			wr(ADDR_BYTE_INDEX, idx);
			rd(ADDR_BYTE_INDEX, v);
			chk(v, idx & 8'h3F);
			nvm_write(idx & 8'h3F, dat);
			nvm_read(idx & 8'h3F, dat);
		end
		// Interrupt delivery, masking and service
		wr(ADDR_INTC, 8'h1F);
		idle(3);
		chk({7'h00, vector_req}, 8'h01);
		int_ack = 1'b1;
		@(posedge ref_clk);
		#1;
		int_ack = 1'b0;
		idle(3);
		chk({7'h00, vector_req}, 8'h00);
		rd(ADDR_INTC, v);
		chk(v, 8'h17);
		for (int k = 0; k < 4; k++) begin
			stack_full = (k == 3);
			wr(ADDR_INTC, (k == 3) ? 8'h1F : (8'h1F & ~(8'h01 << k)));
			idle(3);
			chk({7'h00, vector_req}, 8'h00);
		end
		stack_full = 1'b0;
		wr(ADDR_INTC, 8'h1F);
		idle(3);
		chk({7'h00, vector_req}, 8'h01);
		end_sim();
	end
endmodule
